//--- tb/sps_motor_model.sv
// Transistor array and lamp model on the coil port
`timescale 1ns/1ps
module sps_motor_model (
    // Coil drive
    input wire logic [3:0] coil_q,
    // Lamp state, 1 = lit
    output logic [3:0] lamp_lit
);
    logic [3:0] collector_n;
    // A conducting switch pulls its collector low
    assign collector_n = ~coil_q;
    // Lamp on the collector lights while its coil is energized
    assign lamp_lit = ~collector_n;
endmodule

//--- tb/tb_stepper_phase_sequencer.sv
// Self-checking bench for the stepper phase sequencer
`timescale 1ns/1ps
module tb_stepper_phase_sequencer;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic step_enable = 1'b0;
    logic half_step = 1'b0;
    logic dir_ccw = 1'b0;
    logic [sps_pkg::HOLD_W-1:0] hold_cycles = 16'h0003;
    logic [3:0] coil_q;
    logic [3:0] indicator_n_q;
    logic [3:0] lamp_lit;
    int fail_count = 0;
    int check_count = 0;
    always #10 sys_clk = ~sys_clk;
    sps_sequencer dut_u (.sys_clk(sys_clk), .rst(rst), .step_enable(step_enable),
        .half_step(half_step), .dir_ccw(dir_ccw), .hold_cycles(hold_cycles),
        .coil_q(coil_q), .indicator_n_q(indicator_n_q));
    sps_motor_model motor_u (.coil_q(coil_q), .lamp_lit(lamp_lit));
    task automatic check_nib(input string what, input logic [3:0] e, input logic [3:0] s);
        check_count++;
        if (s !== e)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic check_cnt(input string what, input int e, input int s);
        check_count++;
        if (s != e)
        begin
            fail_count++;
            $display("MISMATCH %s expected %0d seen %0d", what, e, s);
        end
    endtask
    // Clockwise half step order, coil_a written leftmost, so reverse onto the port
    function automatic logic [3:0] exp_pat(input int k);
        logic [3:0] p;
        case (k & 7)
            0: p = 4'hA;
            1: p = 4'h8;
            2: p = 4'h9;
            3: p = 4'h1;
            4: p = 4'h5;
            5: p = 4'h4;
            6: p = 4'h6;
            default: p = 4'h2;
        endcase
        return {p[0], p[1], p[2], p[3]};
    endfunction
    // Counts cycles until the coil nibble leaves cur; gives up after 2000
    task automatic wait_change(input logic [3:0] cur, output int cnt);
        cnt = 0;
        do
        begin
            @(posedge sys_clk);
            #1;
            cnt++;
        end
        while (coil_q === cur && cnt < 2000);
    endtask
    // Index is kept across disable, so the start is found from the first new pattern
    task automatic walk(input logic half, input logic ccw, input logic [15:0] hold);
        int stride;
        int pos;
        int cnt;
        logic [3:0] cur;
        stride = half ? 1 : 2;
        pos = -1;
        half_step = half;
        dir_ccw = ccw;
        hold_cycles = hold;
        step_enable = 1'b1;
        @(posedge sys_clk);
        #1;
        cur = coil_q;
        wait_change(cur, cnt);
        for (int i = 0; i < 8; i += stride)
            if (exp_pat(i) === coil_q)
                pos = i;
        check_cnt("start", 1, int'(pos >= 0));
        for (int n = 0; n <= 8 / stride; n++)
        begin
            cur = exp_pat(pos + (ccw ? -n : n) * stride);
            check_nib("coil", cur, coil_q);
            check_nib("indicator", ~cur, indicator_n_q);
            check_nib("lamp", cur, lamp_lit);
            wait_change(cur, cnt);
            check_cnt("hold", (hold == 0) ? 1 : int'(hold), cnt);
        end
        step_enable = 1'b0;
        @(posedge sys_clk);
        #1;
        check_nib("coil off", 4'h0, coil_q);
        check_nib("indicator off", 4'hF, indicator_n_q);
    endtask
    task automatic scen_reset();
        repeat (2) @(posedge sys_clk);
        #1;
        check_nib("reset coil", 4'h0, coil_q);
        check_nib("reset indicator", 4'hF, indicator_n_q);
    endtask
    // Reset in mid-run turns the coils off and sends the index back to the first entry
    task automatic scen_mid_reset();
        half_step = 1'b0;
        dir_ccw = 1'b0;
        hold_cycles = 16'h0003;
        step_enable = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        rst = 1'b1;
        @(posedge sys_clk);
        #1;
        check_nib("mid reset coil", 4'h0, coil_q);
        check_nib("mid reset indicator", 4'hF, indicator_n_q);
        rst = 1'b0;
        @(posedge sys_clk);
        #1;
        check_nib("restart coil", exp_pat(0), coil_q);
        step_enable = 1'b0;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        #1000000;
        fail_count++;
        end_of_test();
    end
    initial
    begin
        repeat (20) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        scen_reset();
        walk(1'b0, 1'b0, 16'h0003);
        walk(1'b1, 1'b0, 16'h0002);
        // Half step leaves an odd index, so full counter-clockwise starts from a snap
        walk(1'b1, 1'b0, 16'h0001);
        walk(1'b0, 1'b1, 16'h0001);
        // Zero hold is taken as one cycle
        walk(1'b1, 1'b1, 16'h0000);
        scen_mid_reset();
        end_of_test();
    end
endmodule

//--- verilog/sps_hold_timer.sv
// Interval timer that pulses once per pattern hold time
`timescale 1ns/1ps
module sps_hold_timer (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Timer link
    sps_tick_if.timer tif
);
    logic [sps_pkg::HOLD_W-1:0] cnt_q;
    logic [sps_pkg::HOLD_W-1:0] limit;
    logic tick_q;

    // Zero hold would stall the motor, so it is treated as one cycle
    assign limit = (tif.hold < sps_pkg::HOLD_MIN) ? sps_pkg::HOLD_MIN : tif.hold;
    assign tif.tick = tick_q;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end
        else if (!tif.enable)
        begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end
        else if (cnt_q >= limit - sps_pkg::HOLD_MIN) // RQ6
        begin
            cnt_q <= '0;
            tick_q <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + sps_pkg::HOLD_MIN;
            tick_q <= 1'b0;
        end
    end

    // A one-cycle hold ticks every cycle on purpose, so only longer holds are checked
    property p_tick_spacing;
        @(posedge sys_clk) disable iff (rst)
        tif.tick && tif.enable && limit > sps_pkg::HOLD_MIN |=> !tif.tick;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) // RQ6
        else $error("hold timer ticked two cycles in a row");
endmodule

//--- verilog/sps_pkg.sv
// Constants, step tables and helpers for the stepper phase sequencer
// Behaviour
// RQ1: Four coil outputs sit on bits 0 to 3 of one nibble port.
// RQ2: Coil outputs are active high; 1 energizes the coil, 0 releases it.
// RQ3: Full step clockwise order is 1010, 1001, 0101, 0110, then repeats.
// RQ4: Half step clockwise order is eight patterns starting 1010, then repeats.
// RQ5: Each pattern is one 4-bit nibble, coil_a written as leftmost digit.
// RQ6: A programmable hold time sets how long each pattern stays energized.
// RQ7: Unipolar drive: four switches, one per winding, no polarity reversal.
// RQ8: Board wiring should add a lamp on each transistor collector.
// RQ9: Indicator outputs are active low; low lights the lamp.
// RQ10: Counter-clockwise walks the chosen table backwards with the same hold time.
// RQ11: After reset or while disabled all four coils are driven off.
package sps_pkg;
    localparam int HOLD_W = 16;
    localparam int IDX_W = 3;
    localparam logic [IDX_W-1:0] IDX_RESET = 3'h0;
    localparam logic [IDX_W-1:0] HALF_STRIDE = 3'h1;
    localparam logic [IDX_W-1:0] FULL_STRIDE = 3'h2;
    localparam logic [IDX_W-1:0] EVEN_MASK = 3'h6;
    localparam logic [HOLD_W-1:0] HOLD_MIN = 16'h0001;
    localparam logic [3:0] COIL_OFF = 4'h0;
    // Port nibble values, bit 0 = coil_a; the printed digits read coil_a first
    localparam logic [3:0] PAT_0 = 4'h5;
    localparam logic [3:0] PAT_1 = 4'h1;
    localparam logic [3:0] PAT_2 = 4'h9;
    localparam logic [3:0] PAT_3 = 4'h8;
    localparam logic [3:0] PAT_4 = 4'hA;
    localparam logic [3:0] PAT_5 = 4'h2;
    localparam logic [3:0] PAT_6 = 4'h6;
    localparam logic [3:0] PAT_7 = 4'h4;

    // Full step uses the even entries of the half step table only
    function automatic logic [3:0] step_pattern(input logic [IDX_W-1:0] idx,
                                                input logic half);
        logic [IDX_W-1:0] i;
        i = half ? idx : (idx & EVEN_MASK);
        case (i)
            3'h0: step_pattern = PAT_0;
            3'h1: step_pattern = PAT_1;
            3'h2: step_pattern = PAT_2;
            3'h3: step_pattern = PAT_3;
            3'h4: step_pattern = PAT_4;
            3'h5: step_pattern = PAT_5;
            3'h6: step_pattern = PAT_6;
            default: step_pattern = PAT_7;
        endcase
    endfunction
endpackage

//--- verilog/sps_sequencer.sv
// Stepper phase sequencer top: step index, coil and indicator drive
`timescale 1ns/1ps
module sps_sequencer (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Control
    input wire logic step_enable,
    input wire logic half_step,
    input wire logic dir_ccw,
    input wire logic [sps_pkg::HOLD_W-1:0] hold_cycles,
    // Coil port nibble, bit 0 coil_a .. bit 3 coil_d
    output logic [3:0] coil_q,
    // Lamp outputs, bit 0 indicator_zero .. bit 3 indicator_three
    output logic [3:0] indicator_n_q
);
    logic [sps_pkg::IDX_W-1:0] idx_q;
    logic [sps_pkg::IDX_W-1:0] idx_d;
    logic [sps_pkg::IDX_W-1:0] base;
    logic [sps_pkg::IDX_W-1:0] stride;

    sps_tick_if tif ();

    assign tif.enable = step_enable;
    assign tif.hold = hold_cycles;

    sps_hold_timer u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .tif(tif)
    );

    // Full step snaps an odd half-step position onto the even grid first
    always_comb
    begin
        stride = half_step ? sps_pkg::HALF_STRIDE : sps_pkg::FULL_STRIDE;
        base = half_step ? idx_q : (idx_q & sps_pkg::EVEN_MASK);
        // Stepping from the snapped entry keeps every shown pattern for one full hold
        if (dir_ccw)
            idx_d = base - stride; // RQ10
        else
            idx_d = base + stride; // RQ3 RQ4
    end

    // Position is kept while disabled so the rotor resumes where it stopped
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            idx_q <= sps_pkg::IDX_RESET;
        else if (step_enable && tif.tick) // RQ6
            idx_q <= idx_d;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            coil_q <= sps_pkg::COIL_OFF; // RQ11
        else if (step_enable)
            coil_q <= sps_pkg::step_pattern(idx_q, half_step); // RQ1 RQ2 RQ5 RQ7
        else
            coil_q <= sps_pkg::COIL_OFF; // RQ11
    end

    // Lamps follow the coils inverted, lit while the coil conducts
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            indicator_n_q <= ~sps_pkg::COIL_OFF; // RQ9
        else if (step_enable)
            indicator_n_q <= ~sps_pkg::step_pattern(idx_q, half_step); // RQ9
        else
            indicator_n_q <= ~sps_pkg::COIL_OFF; // RQ9
    end

    // Helper: cycles since the last tick; all ones while idle so the first interval lines up
    logic [sps_pkg::HOLD_W-1:0] gap_q;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            gap_q <= '1;
        else if (!step_enable)
            gap_q <= '1;
        else if (tif.tick)
            gap_q <= '0;
        else
            gap_q <= gap_q + sps_pkg::HOLD_MIN;
    end

    sequence s_run(logic h, logic c);
        step_enable && half_step == h && dir_ccw == c;
    endsequence

    sequence s_steady(logic h, logic c);
        s_run(h, c) [*3];
    endsequence

    property p_off;
        @(posedge sys_clk) disable iff (rst)
        !step_enable |=> coil_q == sps_pkg::COIL_OFF;
    endproperty
    a_off: assert property (p_off) // RQ11
        else $error("coil energized while stepping disabled");

    property p_lamp;
        @(posedge sys_clk) disable iff (rst)
        indicator_n_q == ~coil_q;
    endproperty
    a_lamp: assert property (p_lamp) // RQ9
        else $error("indicator does not mirror coil inverted");

    property p_pattern;
        @(posedge sys_clk) disable iff (rst)
        step_enable |=> coil_q == sps_pkg::step_pattern($past(idx_q), $past(half_step));
    endproperty
    a_pattern: assert property (p_pattern) // RQ1
        else $error("coil nibble does not match step table");

    property p_unipolar;
        @(posedge sys_clk) disable iff (rst)
        !(coil_q[0] && coil_q[1]) && !(coil_q[2] && coil_q[3]);
    endproperty
    a_unipolar: assert property (p_unipolar) // RQ7
        else $error("both windings of one coil pair energized");

    // A pattern change under steady settings must land on the next table entry
    property p_full_cw;
        @(posedge sys_clk) disable iff (rst)
        s_steady(1'b0, 1'b0) ##0 coil_q == sps_pkg::PAT_0 ##1 coil_q != sps_pkg::PAT_0
            |-> coil_q == sps_pkg::PAT_2;
    endproperty
    a_full_cw: assert property (p_full_cw) // RQ3
        else $error("full step clockwise order broken");

    property p_half_cw;
        @(posedge sys_clk) disable iff (rst)
        s_steady(1'b1, 1'b0) ##0 coil_q == sps_pkg::PAT_7 ##1 coil_q != sps_pkg::PAT_7
            |-> coil_q == sps_pkg::PAT_0;
    endproperty
    a_half_cw: assert property (p_half_cw) // RQ4
        else $error("half step clockwise wrap broken");

    property p_full_ccw;
        @(posedge sys_clk) disable iff (rst)
        s_steady(1'b0, 1'b1) ##0 coil_q == sps_pkg::PAT_0 ##1 coil_q != sps_pkg::PAT_0
            |-> coil_q == sps_pkg::PAT_6;
    endproperty
    a_full_ccw: assert property (p_full_ccw) // RQ10
        else $error("full step counter-clockwise order broken");

    property p_full_step_cw;
        @(posedge sys_clk) disable iff (rst)
        s_steady(1'b0, 1'b0) ##0 coil_q == sps_pkg::PAT_2 ##1 coil_q != sps_pkg::PAT_2
            |-> coil_q == sps_pkg::PAT_4;
    endproperty
    a_full_step_cw: assert property (p_full_step_cw) // RQ3
        else $error("full step clockwise second step broken");

    property p_full_wrap_cw;
        @(posedge sys_clk) disable iff (rst)
        s_steady(1'b0, 1'b0) ##0 coil_q == sps_pkg::PAT_6 ##1 coil_q != sps_pkg::PAT_6
            |-> coil_q == sps_pkg::PAT_0;
    endproperty
    a_full_wrap_cw: assert property (p_full_wrap_cw) // RQ3
        else $error("full step clockwise wrap broken");

    property p_half_step_cw;
        @(posedge sys_clk) disable iff (rst)
        s_steady(1'b1, 1'b0) ##0 coil_q == sps_pkg::PAT_0 ##1 coil_q != sps_pkg::PAT_0
            |-> coil_q == sps_pkg::PAT_1;
    endproperty
    a_half_step_cw: assert property (p_half_step_cw) // RQ4
        else $error("half step clockwise first step broken");

    property p_half_mid_cw;
        @(posedge sys_clk) disable iff (rst)
        s_steady(1'b1, 1'b0) ##0 coil_q == sps_pkg::PAT_3 ##1 coil_q != sps_pkg::PAT_3
            |-> coil_q == sps_pkg::PAT_4;
    endproperty
    a_half_mid_cw: assert property (p_half_mid_cw) // RQ4
        else $error("half step clockwise middle step broken");

    property p_half_ccw;
        @(posedge sys_clk) disable iff (rst)
        s_steady(1'b1, 1'b1) ##0 coil_q == sps_pkg::PAT_0 ##1 coil_q != sps_pkg::PAT_0
            |-> coil_q == sps_pkg::PAT_7;
    endproperty
    a_half_ccw: assert property (p_half_ccw) // RQ10
        else $error("half step counter-clockwise wrap broken");

    property p_half_ccw_step;
        @(posedge sys_clk) disable iff (rst)
        s_steady(1'b1, 1'b1) ##0 coil_q == sps_pkg::PAT_5 ##1 coil_q != sps_pkg::PAT_5
            |-> coil_q == sps_pkg::PAT_4;
    endproperty
    a_half_ccw_step: assert property (p_half_ccw_step) // RQ10
        else $error("half step counter-clockwise step broken");

    property p_full_ccw_step;
        @(posedge sys_clk) disable iff (rst)
        s_steady(1'b0, 1'b1) ##0 coil_q == sps_pkg::PAT_4 ##1 coil_q != sps_pkg::PAT_4
            |-> coil_q == sps_pkg::PAT_2;
    endproperty
    a_full_ccw_step: assert property (p_full_ccw_step) // RQ10
        else $error("full step counter-clockwise step broken");

    property p_off_lamp;
        @(posedge sys_clk) disable iff (rst)
        !step_enable |=> indicator_n_q == ~sps_pkg::COIL_OFF;
    endproperty
    a_off_lamp: assert property (p_off_lamp) // RQ9
        else $error("indicator lit while stepping disabled");

    property p_stop_tick;
        @(posedge sys_clk) disable iff (rst)
        !tif.enable |=> !tif.tick;
    endproperty
    a_stop_tick: assert property (p_stop_tick) // RQ11
        else $error("hold timer ticked while stepping disabled");

    property p_hold;
        @(posedge sys_clk) disable iff (rst)
        step_enable && $past(step_enable) && tif.tick && $stable(hold_cycles)
            && hold_cycles > sps_pkg::HOLD_MIN && gap_q != '0
            |-> gap_q == hold_cycles - sps_pkg::HOLD_MIN;
    endproperty
    a_hold: assert property (p_hold) // RQ6
        else $error("pattern hold time differs from programmed interval");
endmodule

//--- verilog/sps_tick_if.sv
// Hold timer link between the sequencer core and its interval timer
`timescale 1ns/1ps
interface sps_tick_if;
    logic enable;
    logic [sps_pkg::HOLD_W-1:0] hold;
    logic tick;
    modport timer (input enable, input hold, output tick);
    modport seq (output enable, output hold, input tick);
endinterface
